// [hw/dspwm_defines.vh]
// register offsets, field positions, reset values and timing constants
`ifndef DSPWM_DEFINES_VH
`define DSPWM_DEFINES_VH
`define A_CTRL      4'h0
`define A_CLKSEL    4'h1
`define A_CNT_L     4'h2
`define A_CNT_H     4'h3
`define A_CMPA_L    4'h4
`define A_CMPA_H    4'h5
`define A_CMPB_L    4'h6
`define A_CMPB_H    4'h7
`define A_CAP_L     4'h8
`define A_CAP_H     4'h9
`define A_FLAGS     4'hA
`define A_DIR       4'hB
`define F_MODE_LSB  0
`define F_COMA_LSB  4
`define F_COMB_LSB  6
`define RST_CTRL    8'h00
`define RST_CLKSEL  3'h0
`define RST_WORD    16'h0000
`define TOP_8B      16'h00FF
`define TOP_9B      16'h01FF
`define TOP_10B     16'h03FF
`define FLG_OVF     0
`define FLG_CMPA    1
`define FLG_CMPB    2
`define FLG_CAP     3
`define PS_1        11'h001
`define PS_8        11'h008
`define PS_64       11'h040
`define PS_256      11'h100
`define PS_1024     11'h400
`endif

// [hw/dual_slope_pwm_timer.v]
// dual-slope 16-bit pwm timer with avalon-mm register slave
// Operation
// RL1 - modes 1,2,3,10,11 count 0 up to top then back to zero
// RL2 - phase correct top: ff, 1ff, 3ff, capture or compare a; hold once
// RL3 - non-inverting clears on up match, sets on down; inverting opposite
// RL4 - output mode two is non-inverted, three is inverted pwm
// RL5 - compare output reaches pin only when direction bit is output
// RL6 - software keeps register top at least 0x0003, at most 16-bit
// RL7 - phase correct sets overflow flag whenever counter reaches zero
// RL8 - phase correct register top sets a or capture flag at top update
// RL9 - phase correct compare registers load buffers at top
// RL10 - fixed top modes mask compare write bits above top width
// RL11 - each compare unit flags when counter equals its compare value
// RL12 - software keeps top not below compare values, else no match
// RL13 - phase correct: zero gives low, top gives high; inverted opposite
// RL14 - modes 8,9 frequency correct, top from capture or compare a
// RL15 - frequency correct loads compare buffers and sets overflow at zero
// RL16 - frequency correct register top sets a or capture flag at top
// RL17 - frequency correct: zero gives low, top gives high; inverted opposite
// RL18 - software prefers frequency correct mode when top changes
// RL19 - software prefers compare a top when base frequency changes
// RL20 - timer tick is clock divided by 1, 8, 64, 256 or 1024
// RL21 - compare a writes go to buffer, loaded at update point
// RL22 - high byte to shared temp first; low write commits, low read latches
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dspwm_defines.vh"
module dual_slope_pwm_timer (
  input  wire        CLK,
  input  wire        RSTN,
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  output reg         COMPARE_OUTPUT_A,
  output reg         COMPARE_OUTPUT_A_OE,
  output reg         COMPARE_OUTPUT_B,
  output reg         COMPARE_OUTPUT_B_OE
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [7:0]  ctrl_ff;
  reg  [2:0]  clksel_ff;
  reg  [1:0]  dir_ff;
  reg  [7:0]  temp_ff;
  reg  [15:0] cnt_ff;
  reg         down_ff;
  reg  [15:0] cmp_ff [0:1];
  reg  [15:0] cmpbuf_ff [0:1];
  reg  [15:0] cap_ff;
  reg  [3:0]  flags_ff;
  reg  [10:0] pre_ff;
  reg         oc_a_ff;
  reg         oc_b_ff;
  reg         done_ff;

  wire [3:0]  mode = ctrl_ff[`F_MODE_LSB+3:`F_MODE_LSB];
  wire [1:0]  com_a = ctrl_ff[`F_COMA_LSB+1:`F_COMA_LSB];
  wire [1:0]  com_b = ctrl_ff[`F_COMB_LSB+1:`F_COMB_LSB];
  wire        pc_mode = (mode == 4'h1) || (mode == 4'h2) ||
                        (mode == 4'h3) || (mode == 4'hA) ||
                        (mode == 4'hB);
  wire        pfc_mode = (mode == 4'h8) || (mode == 4'h9);
  wire        run = pc_mode || pfc_mode;
  wire        top_cap = (mode == 4'hA) || (mode == 4'h8);
  wire        top_cmpa = (mode == 4'hB) || (mode == 4'h9);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [15:0] fixed_mask;
    input [3:0] m;
    begin
      case (m)
        4'h1: fixed_mask = `TOP_8B;
        4'h2: fixed_mask = `TOP_9B;
        4'h3: fixed_mask = `TOP_10B;
        default: fixed_mask = 16'hFFFF;
      endcase
    end
  endfunction

  // non-inverting clears on up match; inverting is the opposite
  function next_oc;
    input       cur;
    input [1:0] com;
    input       hit;
    input       dn;
    begin
      if (hit && com[1])
        next_oc = com[0] ^ dn;       // RL3 RL4
      else
        next_oc = cur;
    end
  endfunction

  reg [15:0] top;
  always @* begin
    if (top_cap)
      top = cap_ff;                  // RL2 RL14
    else if (top_cmpa)
      top = cmp_ff[0];
    else
      top = fixed_mask(mode);        // RL2
  end

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  reg [10:0] div;
  always @* begin
    case (clksel_ff)
      3'h1: div = `PS_1;
      3'h2: div = `PS_8;
      3'h3: div = `PS_64;
      3'h4: div = `PS_256;
      3'h5: div = `PS_1024;
      default: div = 11'h000;
    endcase
  end
  wire tick = run && (div != 11'h000) &&
              (pre_ff >= div - 11'h001); // RL20

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire acc = (AVS_READ || AVS_WRITE) && !done_ff;
  // writes land on the edge that sees waitrequest low
  wire wr = AVS_WRITE && !AVS_WAITREQUEST;
  wire rd = AVS_READ && acc;
  wire [7:0] wb = AVS_WRITEDATA[7:0];
  wire [15:0] wword = {temp_ff, wb};                     // RL22
  wire [15:0] wmask = wword & fixed_mask(mode);          // RL10
  wire wr_cnt = wr && (AVS_ADDRESS == `A_CNT_L);
  wire wr_ca = wr && (AVS_ADDRESS == `A_CMPA_L);
  wire wr_cb = wr && (AVS_ADDRESS == `A_CMPB_L);

  // ------------------------------------------------------------
  // counter events
  // ------------------------------------------------------------
  wire at_top = (cnt_ff == top);
  wire at_bot = (cnt_ff == 16'h0000);
  wire upd_pc = tick && pc_mode && at_top;               // RL9
  wire upd_pfc = tick && pfc_mode && at_bot;             // RL15
  wire upd = upd_pc || upd_pfc;
  wire hit_a = tick && (cnt_ff == cmp_ff[0]);            // RL11
  wire hit_b = tick && (cnt_ff == cmp_ff[1]);            // RL11
  wire ev_ovf = tick && at_bot;                          // RL7 RL15
  wire ev_top = tick && at_top;                          // RL8 RL16

  reg [3:0] set_f;
  always @* begin
    set_f = 4'h0;
    set_f[`FLG_OVF] = ev_ovf;
    set_f[`FLG_CMPA] = hit_a || (ev_top && top_cmpa);
    set_f[`FLG_CMPB] = hit_b;
    set_f[`FLG_CAP] = ev_top && top_cap;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  integer i;
  always @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_ff <= `RST_CTRL;
      clksel_ff <= `RST_CLKSEL;
      dir_ff <= 2'h0;
      temp_ff <= 8'h00;
      cnt_ff <= `RST_WORD;
      down_ff <= 1'b0;
      cap_ff <= `RST_WORD;
      flags_ff <= 4'h0;
      pre_ff <= 11'h000;
      oc_a_ff <= 1'b0;
      oc_b_ff <= 1'b0;
      done_ff <= 1'b0;
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
      COMPARE_OUTPUT_A <= 1'b0;
      COMPARE_OUTPUT_A_OE <= 1'b0;
      COMPARE_OUTPUT_B <= 1'b0;
      COMPARE_OUTPUT_B_OE <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        cmp_ff[i] <= `RST_WORD;
        cmpbuf_ff[i] <= `RST_WORD;
      end
    end else begin
      // --------------------------------------------------
      // bus answer
      // --------------------------------------------------
      // one-wait-state slave: answer on the cycle after the request
      done_ff <= acc;
      AVS_WAITREQUEST <= !acc;
      if (rd) begin
        case (AVS_ADDRESS)
          `A_CTRL:   AVS_READDATA <= {24'h0, ctrl_ff};
          `A_CLKSEL: AVS_READDATA <= {29'h0, clksel_ff};
          `A_CNT_L:  AVS_READDATA <= {24'h0, cnt_ff[7:0]};
          `A_CNT_H:  AVS_READDATA <= {24'h0, temp_ff};
          `A_CMPA_L: AVS_READDATA <= {24'h0, cmpbuf_ff[0][7:0]};
          `A_CMPA_H: AVS_READDATA <= {24'h0, cmpbuf_ff[0][15:8]};
          `A_CMPB_L: AVS_READDATA <= {24'h0, cmpbuf_ff[1][7:0]};
          `A_CMPB_H: AVS_READDATA <= {24'h0, cmpbuf_ff[1][15:8]};
          `A_CAP_L:  AVS_READDATA <= {24'h0, cap_ff[7:0]};
          `A_CAP_H:  AVS_READDATA <= {24'h0, temp_ff};
          `A_FLAGS:  AVS_READDATA <= {28'h0, flags_ff};
          `A_DIR:    AVS_READDATA <= {30'h0, dir_ff};
          default:   AVS_READDATA <= 32'h00000000;
        endcase
      end

      // --------------------------------------------------
      // shared temp byte
      // --------------------------------------------------
      // counter and capture low-byte reads latch the high byte into the shared temp
      if (rd && AVS_ADDRESS == `A_CNT_L)
        temp_ff <= cnt_ff[15:8];                          // RL22
      else if (rd && AVS_ADDRESS == `A_CAP_L)
        temp_ff <= cap_ff[15:8];                          // RL22
      else if (wr && (AVS_ADDRESS == `A_CNT_H ||
               AVS_ADDRESS == `A_CMPA_H ||
               AVS_ADDRESS == `A_CMPB_H ||
               AVS_ADDRESS == `A_CAP_H))
        temp_ff <= wb;                                    // RL22

      // --------------------------------------------------
      // control writes
      // --------------------------------------------------
      if (wr && AVS_ADDRESS == `A_CTRL)
        ctrl_ff <= wb;
      if (wr && AVS_ADDRESS == `A_CLKSEL)
        clksel_ff <= wb[2:0];
      if (wr && AVS_ADDRESS == `A_DIR)
        dir_ff <= wb[1:0];
      if (wr && AVS_ADDRESS == `A_CAP_L)
        cap_ff <= wword;

      // --------------------------------------------------
      // flags
      // --------------------------------------------------
      // set wins over a write-one clear
      if (wr && AVS_ADDRESS == `A_FLAGS)
        flags_ff <= (flags_ff & ~wb[3:0]) | set_f;
      else
        flags_ff <= flags_ff | set_f;

      // --------------------------------------------------
      // compare buffers
      // --------------------------------------------------
      if (wr_ca)
        cmpbuf_ff[0] <= wmask;                            // RL21 RL10
      if (wr_cb)
        cmpbuf_ff[1] <= wmask;                            // RL10
      if (upd) begin
        cmp_ff[0] <= wr_ca ? wmask : cmpbuf_ff[0];        // RL9 RL15 RL21
        cmp_ff[1] <= wr_cb ? wmask : cmpbuf_ff[1];
      end

      // --------------------------------------------------
      // prescaler
      // --------------------------------------------------
      if (!run || tick)
        pre_ff <= 11'h000;
      else
        pre_ff <= pre_ff + 11'h001;                       // RL20

      // --------------------------------------------------
      // up/down counter
      // --------------------------------------------------
      if (wr_cnt) begin
        cnt_ff <= wword;                                  // RL22
      end else if (tick) begin                            // RL1
        if (at_top && !down_ff) begin
          down_ff <= 1'b1;
          cnt_ff <= cnt_ff - 16'h0001;                    // RL2 RL14
        end else if (at_bot && down_ff) begin
          down_ff <= 1'b0;
          cnt_ff <= cnt_ff + 16'h0001;
        end else if (down_ff) begin
          cnt_ff <= cnt_ff - 16'h0001;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end

      // --------------------------------------------------
      // compare outputs
      // --------------------------------------------------
      // match at top counts as downcounting, at bottom as upcounting
      // so non-inverting, value zero stays low and value top stays high; inverting opposite
      oc_a_ff <= next_oc(oc_a_ff, com_a, hit_a,
                         (down_ff && !at_bot) || at_top); // RL3 RL13 RL17
      oc_b_ff <= next_oc(oc_b_ff, com_b, hit_b,
                         (down_ff && !at_bot) || at_top); // RL3 RL13 RL17

      // --------------------------------------------------
      // pins
      // --------------------------------------------------
      COMPARE_OUTPUT_A <= oc_a_ff;
      COMPARE_OUTPUT_B <= oc_b_ff;
      COMPARE_OUTPUT_A_OE <= dir_ff[0] && com_a[1];       // RL5
      COMPARE_OUTPUT_B_OE <= dir_ff[1] && com_b[1];       // RL5
    end
  end

endmodule

// [sim/dspwm_sva.sv]
// assertion checker for the dual-slope pwm timer ports
`timescale 1ns/1ps
module dspwm_sva (
  input wire        CLK,
  input wire        RSTN,
  input wire [3:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        COMPARE_OUTPUT_A,
  input wire        COMPARE_OUTPUT_A_OE,
  input wire        COMPARE_OUTPUT_B,
  input wire        COMPARE_OUTPUT_B_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire req    = AVS_READ || AVS_WRITE;
  wire wr_ack = AVS_WRITE && !AVS_WAITREQUEST;
  sequence s_taken;
    req && AVS_WAITREQUEST;
  endsequence
  sequence s_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  answer_one_cycle_a: assert property (s_taken |=> s_answer)
    else $error("bus answer missing or too long");
  idle_no_answer_a: assert property (!req |=> AVS_WAITREQUEST)
    else $error("answer without request");
  answer_has_req_a: assert property (!AVS_WAITREQUEST |-> req)
    else $error("answer while request dropped");
  unmapped_zero_a: assert property (
    (s_taken and AVS_READ && AVS_ADDRESS >= 4'hC) |=> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  read_hold_a: assert property (
    $changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
    else $error("read data changed outside a read");
  oe_a_cause_a: assert property (
    $changed(COMPARE_OUTPUT_A_OE)
    |-> $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("enable a changed without a write");
  oe_b_cause_a: assert property (
    $changed(COMPARE_OUTPUT_B_OE)
    |-> $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("enable b changed without a write");
endmodule
bind dual_slope_pwm_timer dspwm_sva u_dspwm_sva (.CLK(CLK), .RSTN(RSTN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A),
  .COMPARE_OUTPUT_A_OE(COMPARE_OUTPUT_A_OE),
  .COMPARE_OUTPUT_B(COMPARE_OUTPUT_B),
  .COMPARE_OUTPUT_B_OE(COMPARE_OUTPUT_B_OE));

// [sim/pwm_pin_load.sv]
// load at a pwm pin: driven level, or a toggling float
`timescale 1ns/1ps
module pwm_pin_load (
  input  wire clk,
  input  wire level,
  input  wire enable,
  output wire pin
);
  reg last_ff = 1'h0;
  assign pin = enable ? level : ~last_ff;
  always @(posedge clk) begin
    last_ff <= pin;
  end
endmodule

// [sim/tb.sv]
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
`include "dspwm_defines.vh"
module tb;
  reg         CLK, RSTN, AVS_READ, AVS_WRITE;
  reg  [3:0]  AVS_ADDRESS;
  reg  [31:0] AVS_WRITEDATA;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST, oa, oa_oe, ob, ob_oe, pa, pb;
  integer     failures, check_count, t, c, ca, n, cs, ha, hb;
  int         mq[$] = '{1, 2, 3, 10, 8, 11, 9};
  reg  [7:0]  q, q2;
  reg  [15:0] v;
  reg  [3:0]  m;
  reg  [1:0]  cm;
  dual_slope_pwm_timer u_dual_slope_pwm_timer (.CLK(CLK), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARE_OUTPUT_A(oa),
    .COMPARE_OUTPUT_A_OE(oa_oe), .COMPARE_OUTPUT_B(ob),
    .COMPARE_OUTPUT_B_OE(ob_oe));
  pwm_pin_load u_load_a (.clk(CLK), .level(oa), .enable(oa_oe), .pin(pa));
  pwm_pin_load u_load_b (.clk(CLK), .level(ob), .enable(ob_oe), .pin(pb));
  // ----
  // tasks
  // ----
  task test_done;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d, output [7:0] r);
    integer i;
    begin
      // entered just after a rising edge; held until waitrequest low
      AVS_ADDRESS   <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE     <= w;
      AVS_READ      <= !w;
      i = 0;
      do begin
        @(posedge CLK);
        i = i + 1;
      end while (AVS_WAITREQUEST !== 1'h0 && i < 100);
      if (i >= 100) begin
        failures = failures + 1;
        test_done;
      end
      r = AVS_READDATA[7:0];
      AVS_READ  <= 1'h0;
      AVS_WRITE <= 1'h0;
      @(posedge CLK);
    end
  endtask
  task wr16(input [3:0] a, input [15:0] d);
    begin
      bus(1'h1, a + 4'h1, d[15:8], q);
      bus(1'h1, a, d[7:0], q);
    end
  endtask
  task rd16(input [3:0] a);
    begin
      bus(1'h0, a, 8'h00, q);
      bus(1'h0, a + 4'h1, 8'h00, q2);
      v = {q2, q};
    end
  endtask
  // ----
  // clock and main sequence
  // ----
  initial begin
    CLK = 1'h0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    failures      = 0;
    check_count   = 0;
    RSTN          = 1'h0;
    AVS_READ      = 1'h0;
    AVS_WRITE     = 1'h0;
    AVS_ADDRESS   = 4'h0;
    AVS_WRITEDATA = 32'h0;
    void'($urandom(4));
    repeat (12) @(posedge CLK);
    RSTN <= 1'h1;
    bus(1'h0, `A_CTRL, 8'h00, q);
    chk("ctrl reset", `RST_CTRL, q);
    bus(1'h1, 4'hE, 8'h5A, q);
    bus(1'h0, 4'hE, 8'h00, q);
    chk("unmapped read", 0, q);
    foreach (mq[i]) begin
      m  = mq[i][3:0];
      cm = 2'h2 + $urandom % 2;
      t  = m == 1 ? 255 : m == 2 ? 511 : m == 3 ? 1023 : 3 + $urandom % 22;
      cs = t > 24 ? 1 : 1 + $urandom % 3;
      n  = cs == 1 ? 1 : cs == 2 ? 8 : 64;
      c  = i == 0 ? 0 : $urandom % (t + 1);
      ca = m == 11 || m == 9 ? t : 3 + $urandom % (t - 2);
      bus(1'h1, `A_CLKSEL, 8'h00, q);
      bus(1'h1, `A_CTRL, {cm, cm ^ 2'h1, m}, q);
      bus(1'h1, `A_DIR, 8'h03, q);
      bus(1'h1, `A_FLAGS, 8'h0F, q);
      wr16(`A_CAP_L, t[15:0]);
      wr16(`A_CMPA_L, ca[15:0]);
      wr16(`A_CMPB_L, m < 4 ? c[15:0] | 16'hA000 : c[15:0]);
      wr16(`A_CNT_L, 16'h0000);
      bus(1'h1, `A_CLKSEL, cs[7:0], q);
      rd16(`A_CMPB_L);
      chk("compare b", c, v);
      // an older compare a top can stretch the first period
      repeat ((6 * t + 50) * n) @(posedge CLK);
      chk("enables on", 3, {ob_oe, oa_oe});
      ha = 0;
      hb = 0;
      repeat (2 * t * n) begin
        @(negedge CLK);
        ha = ha + pa;
        hb = hb + pb;
      end
      @(posedge CLK);
      chk("high a", cm[0] ? 2 * ca * n : 2 * (t - ca) * n, ha);
      chk("high b", cm[0] ? 2 * (t - c) * n : 2 * c * n, hb);
      bus(1'h0, `A_FLAGS, 8'h00, q);
      chk("flags", m[3] && !m[0] ? 8'h0F : 8'h07, q);
      rd16(`A_CNT_L);
      chk("count range", 1, v <= t);
      bus(1'h1, `A_DIR, 8'h00, q);
      repeat (4) @(posedge CLK);
      chk("enables off", 0, {ob_oe, oa_oe});
    end
    test_done;
  end
endmodule
